// file: bstap_consts.svh
`ifndef BSTAP_CONSTS_SVH
`define BSTAP_CONSTS_SVH

`define BSTAP_IR_W 5
`define BSTAP_IR_EXTEST 5'h00
`define BSTAP_IR_SAMPLE 5'h01
`define BSTAP_IR_USER_ONE 5'h02
`define BSTAP_IR_USER_TWO 5'h03
`define BSTAP_IR_CFG_RD 5'h04
`define BSTAP_IR_CFG_WR 5'h05
`define BSTAP_IR_INTEST 5'h07
`define BSTAP_IR_USERCODE 5'h08
`define BSTAP_IR_IDCODE 5'h09
`define BSTAP_IR_HIGHZ 5'h0A
`define BSTAP_IR_STARTUP 5'h0C
`define BSTAP_IR_BYPASS 5'h1F
`define BSTAP_IR_CAPTURE 5'h01

`define BSTAP_WORD_W 32
`define BSTAP_WCNT_LAST 5'h1F
`define BSTAP_CELLS_PER_IO 3
`define BSTAP_CELL_IN 0
`define BSTAP_CELL_OUT 1
`define BSTAP_CELL_OE 2
`define BSTAP_ID_LSB 1'h1
`define BSTAP_USERCODE_BLANK 32'hFFFFFFFF
`define BSTAP_ROWS_MIN 9'h010
`define BSTAP_ROWS_MAX 9'h068

`endif

// file: bstap_pkg.sv
package bstap_pkg;

	typedef enum logic [3:0] {
		BSTAP_TLR = 4'h0,
		BSTAP_RTI = 4'h1,
		BSTAP_SEL_DR = 4'h3,
		BSTAP_CAP_DR = 4'h2,
		BSTAP_SH_DR = 4'h6,
		BSTAP_EX1_DR = 4'h7,
		BSTAP_PA_DR = 4'h5,
		BSTAP_EX2_DR = 4'h4,
		BSTAP_UPD_DR = 4'hC,
		BSTAP_SEL_IR = 4'hD,
		BSTAP_CAP_IR = 4'hF,
		BSTAP_SH_IR = 4'hE,
		BSTAP_EX1_IR = 4'hA,
		BSTAP_PA_IR = 4'hB,
		BSTAP_EX2_IR = 4'h9,
		BSTAP_UPD_IR = 4'h8
	} bstap_state_t;

	typedef enum logic [2:0] {
		BSTAP_DR_BYPASS = 3'h0,
		BSTAP_DR_BSR = 3'h1,
		BSTAP_DR_IDCODE = 3'h2,
		BSTAP_DR_USERCODE = 3'h3,
		BSTAP_DR_CFG_RD = 3'h4,
		BSTAP_DR_CFG_WR = 3'h5,
		BSTAP_DR_USER_ONE = 3'h6,
		BSTAP_DR_USER_TWO = 3'h7
	} bstap_dr_sel_t;

endpackage

// file: bstap_sync.sv
`timescale 1ns/10ps
module bstap_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	if (W < 1) begin : g_bad_w
		$error("bstap_sync: W must be at least 1");
	end

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	for (genvar b = 0; b < W; b++) begin : g_bit
		// First stage feeds only the second stage
		always_ff @(posedge clk_i) begin
			if (!nrst_i) begin
				meta_q[b] <= 1'h0;
				sync_q[b] <= 1'h0;
			end else begin
				meta_q[b] <= async_i[b];
				sync_q[b] <= meta_q[b];
			end
		end
	end

	assign sync_o = sync_q;
endmodule

// file: bstap_buf.sv
`timescale 1ns/10ps
module bstap_buf #(
	parameter int W = 32,
	parameter int DEPTH = 2
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic in_valid_i,
	input wire logic [W-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output logic [W-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int AW = (DEPTH > 2) ? $clog2(DEPTH) : 1;

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || W < 1) begin : g_bad_cfg
		$error("bstap_buf: DEPTH must be a power of two of at least 2");
	end

	logic [W-1:0] mem_q [DEPTH];
	logic [W-1:0] mem_d [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] cnt_q, cnt_d;
	logic space_q, space_d;
	logic push, pop;

	assign out_valid_o = (cnt_q != '0);
	assign out_data_o = mem_q[rd_q];
	assign in_ready_o = space_q;

	always_comb begin
		mem_d = mem_q;
		push = in_valid_i & space_q;
		pop = out_valid_o & out_ready_i;
		wr_d = wr_q;
		rd_d = rd_q;
		if (push) begin
			mem_d[wr_q] = in_data_i;
			wr_d = wr_q + AW'(1);
		end
		if (pop) begin
			rd_d = rd_q + AW'(1);
		end
		cnt_d = cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
		// Registered ready: the producer sees back-pressure from the first cycle the buffer is full
		space_d = (cnt_d != (AW + 1)'(DEPTH));
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			space_q <= 1'h0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
			space_q <= space_d;
			mem_q <= mem_d;
		end
	end
endmodule

// file: bstap_top.sv
`timescale 1ns/10ps
`include "bstap_consts.svh"
module bstap_top #(
	parameter int N_IO = 8,
	parameter int N_IN = 2,
	parameter logic [3:0] ID_VERSION = 4'h0,
	parameter logic [6:0] ID_FAMILY = 7'h11, // Arbitrary value
	parameter logic [8:0] ID_ROWS = 9'h010,
	parameter logic [10:0] ID_MAKER = 11'h2A5 // Arbitrary value
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic tck_i,
	input wire logic tms_i,
	input wire logic tdi_i,
	output logic tdo_o,
	output logic tdo_oe_o,
	input wire logic config_done_i,
	input wire logic startup_clock_source_i,
	input wire logic [`BSTAP_WORD_W-1:0] usercode_i,
	input wire logic cfg_rd_valid_i,
	input wire logic [`BSTAP_WORD_W-1:0] cfg_rd_data_i,
	output logic cfg_rd_ready_o,
	output logic cfg_wr_valid_o,
	output logic [`BSTAP_WORD_W-1:0] cfg_wr_data_o,
	output logic startup_step_o,
	output logic user_select_one_o,
	output logic user_select_two_o,
	output logic user_dr_clock_one_o,
	output logic user_dr_clock_two_o,
	output logic user_tdi_o,
	output logic user_reset_o,
	output logic user_shift_o,
	output logic user_update_o,
	input wire logic user_serial_out_one_i,
	input wire logic user_serial_out_two_i,
	input wire logic [N_IO-1:0] pad_in_i,
	input wire logic [N_IO-1:0] core_out_i,
	input wire logic [N_IO-1:0] core_oe_i,
	output logic [N_IO-1:0] pad_out_o,
	output logic [N_IO-1:0] pad_oe_o,
	output logic [N_IO-1:0] core_in_o,
	input wire logic [N_IN-1:0] inonly_pad_i,
	output logic [N_IN-1:0] inonly_core_o
);
	import bstap_pkg::*;

	localparam int L = `BSTAP_CELLS_PER_IO * N_IO + N_IN;
	localparam int SW = 3 + N_IO + N_IN;
	localparam int WW = `BSTAP_WORD_W;

	if (N_IO < 1 || N_IN < 1) begin : g_bad_io
		$error("bstap_top: N_IO and N_IN must be at least 1");
	end
	if (ID_ROWS < `BSTAP_ROWS_MIN || ID_ROWS > `BSTAP_ROWS_MAX) begin : g_bad_rows
		$error("bstap_top: ID_ROWS outside the family range");
	end

	logic [SW-1:0] sync_s;
	logic tck_s, tms_s, tdi_s, rise, fall;
	logic [N_IO-1:0] pad_s;
	logic [N_IN-1:0] inp_s;

	bstap_sync #(.W(SW)) u_sync (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.async_i({inonly_pad_i, pad_in_i, tdi_i, tms_i, tck_i}),
		.sync_o(sync_s)
	);

	assign tck_s = sync_s[0];
	assign tms_s = sync_s[1];
	assign tdi_s = sync_s[2];
	assign pad_s = sync_s[3 +: N_IO];
	assign inp_s = sync_s[3 + N_IO +: N_IN];

	logic rd_valid, rd_pop;
	logic [WW-1:0] rd_data;

	// Readback words wait here so a slow shift-out never drops one
	bstap_buf #(.W(WW), .DEPTH(2)) u_rdbuf (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.in_valid_i(cfg_rd_valid_i),
		.in_data_i(cfg_rd_data_i),
		.in_ready_o(cfg_rd_ready_o),
		.out_valid_o(rd_valid),
		.out_data_o(rd_data),
		.out_ready_i(rd_pop)
	);

	function automatic bstap_state_t tap_next(bstap_state_t s, logic m);
		bstap_state_t n;
		case (s)
			BSTAP_TLR: n = m ? BSTAP_TLR : BSTAP_RTI;
			BSTAP_RTI: n = m ? BSTAP_SEL_DR : BSTAP_RTI;
			BSTAP_SEL_DR: n = m ? BSTAP_SEL_IR : BSTAP_CAP_DR;
			BSTAP_CAP_DR: n = m ? BSTAP_EX1_DR : BSTAP_SH_DR;
			BSTAP_SH_DR: n = m ? BSTAP_EX1_DR : BSTAP_SH_DR;
			BSTAP_EX1_DR: n = m ? BSTAP_UPD_DR : BSTAP_PA_DR;
			BSTAP_PA_DR: n = m ? BSTAP_EX2_DR : BSTAP_PA_DR;
			BSTAP_EX2_DR: n = m ? BSTAP_UPD_DR : BSTAP_SH_DR;
			BSTAP_UPD_DR: n = m ? BSTAP_SEL_DR : BSTAP_RTI;
			BSTAP_SEL_IR: n = m ? BSTAP_TLR : BSTAP_CAP_IR;
			BSTAP_CAP_IR: n = m ? BSTAP_EX1_IR : BSTAP_SH_IR;
			BSTAP_SH_IR: n = m ? BSTAP_EX1_IR : BSTAP_SH_IR;
			BSTAP_EX1_IR: n = m ? BSTAP_UPD_IR : BSTAP_PA_IR;
			BSTAP_PA_IR: n = m ? BSTAP_EX2_IR : BSTAP_PA_IR;
			BSTAP_EX2_IR: n = m ? BSTAP_UPD_IR : BSTAP_SH_IR;
			BSTAP_UPD_IR: n = m ? BSTAP_SEL_DR : BSTAP_RTI;
			default: n = BSTAP_TLR;
		endcase
		return n;
	endfunction

	function automatic bstap_dr_sel_t dr_decode(logic [`BSTAP_IR_W-1:0] ir, logic done);
		bstap_dr_sel_t s;
		case (ir)
			`BSTAP_IR_EXTEST, `BSTAP_IR_SAMPLE, `BSTAP_IR_INTEST: s = BSTAP_DR_BSR;
			`BSTAP_IR_USER_ONE: s = done ? BSTAP_DR_USER_ONE : BSTAP_DR_BYPASS;
			`BSTAP_IR_USER_TWO: s = done ? BSTAP_DR_USER_TWO : BSTAP_DR_BYPASS;
			`BSTAP_IR_CFG_RD: s = BSTAP_DR_CFG_RD;
			`BSTAP_IR_CFG_WR: s = BSTAP_DR_CFG_WR;
			`BSTAP_IR_USERCODE: s = BSTAP_DR_USERCODE;
			`BSTAP_IR_IDCODE: s = BSTAP_DR_IDCODE;
			default: s = BSTAP_DR_BYPASS;
		endcase
		return s;
	endfunction

	// Controller and instruction register
	bstap_state_t state_q, state_d;
	logic [`BSTAP_IR_W-1:0] ir_q, ir_d, ir_sh_q, ir_sh_d;
	logic tck_prev_q;
	bstap_dr_sel_t dr_sel;

	assign rise = tck_s & ~tck_prev_q;
	assign fall = ~tck_s & tck_prev_q;
	assign dr_sel = dr_decode(ir_q, config_done_i);

	always_comb begin
		state_d = state_q;
		ir_d = ir_q;
		ir_sh_d = ir_sh_q;
		if (rise) begin
			state_d = tap_next(state_q, tms_s);
			case (state_q)
				BSTAP_TLR: ir_d = `BSTAP_IR_IDCODE;
				BSTAP_CAP_IR: ir_sh_d = `BSTAP_IR_CAPTURE;
				BSTAP_SH_IR: ir_sh_d = {tdi_s, ir_sh_q[`BSTAP_IR_W-1:1]};
				BSTAP_UPD_IR: ir_d = ir_sh_q;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			state_q <= BSTAP_TLR;
			ir_q <= `BSTAP_IR_IDCODE;
			ir_sh_q <= `BSTAP_IR_CAPTURE;
			tck_prev_q <= 1'h0;
		end else begin
			state_q <= state_d;
			ir_q <= ir_d;
			ir_sh_q <= ir_sh_d;
			tck_prev_q <= tck_s;
		end
	end

	// Data registers
	logic [L-1:0] bsr_q, bsr_d, bsu_q, bsu_d;
	logic [WW-1:0] w32_q, w32_d, wr_data_q, wr_data_d;
	logic byp_q, byp_d, wr_valid_q, wr_valid_d;
	logic [4:0] wcnt_q, wcnt_d;
	logic [WW-1:0] id_word;
	logic [N_IO-1:0] bsu_in, bsu_out, bsu_oe;

	assign id_word = {ID_VERSION, ID_FAMILY, ID_ROWS, ID_MAKER, `BSTAP_ID_LSB};

	for (genvar i = 0; i < N_IO; i++) begin : g_cell
		assign bsu_in[i] = bsu_q[`BSTAP_CELLS_PER_IO * i + `BSTAP_CELL_IN];
		assign bsu_out[i] = bsu_q[`BSTAP_CELLS_PER_IO * i + `BSTAP_CELL_OUT];
		assign bsu_oe[i] = bsu_q[`BSTAP_CELLS_PER_IO * i + `BSTAP_CELL_OE];
	end

	always_comb begin
		bsr_d = bsr_q;
		bsu_d = bsu_q;
		w32_d = w32_q;
		byp_d = byp_q;
		wcnt_d = wcnt_q;
		wr_valid_d = 1'h0;
		wr_data_d = wr_data_q;
		rd_pop = 1'h0;
		if (rise) begin
			case (state_q)
				BSTAP_CAP_DR: begin
					case (dr_sel)
						BSTAP_DR_BSR: begin
							// Each bidirectional block captures pad, core output and enable; input-only pins take one cell each
							for (int i = 0; i < N_IO; i++) begin
								bsr_d[`BSTAP_CELLS_PER_IO * i + `BSTAP_CELL_IN] = pad_s[i];
								bsr_d[`BSTAP_CELLS_PER_IO * i + `BSTAP_CELL_OUT] = core_out_i[i];
								bsr_d[`BSTAP_CELLS_PER_IO * i + `BSTAP_CELL_OE] = core_oe_i[i];
							end
							bsr_d[`BSTAP_CELLS_PER_IO * N_IO +: N_IN] = inp_s;
						end
						BSTAP_DR_IDCODE: w32_d = id_word;
						BSTAP_DR_USERCODE: w32_d = config_done_i ? usercode_i : `BSTAP_USERCODE_BLANK;
						BSTAP_DR_CFG_RD: begin
							w32_d = rd_valid ? rd_data : '0;
							rd_pop = rd_valid;
							wcnt_d = '0;
						end
						BSTAP_DR_CFG_WR: wcnt_d = '0;
						default: byp_d = 1'h0;
					endcase
				end
				BSTAP_SH_DR: begin
					if (dr_sel == BSTAP_DR_BSR) begin
						bsr_d = {tdi_s, bsr_q[L-1:1]};
					end
					w32_d = {tdi_s, w32_q[WW-1:1]};
					byp_d = tdi_s;
					wcnt_d = wcnt_q + 5'h01;
					if (wcnt_q == `BSTAP_WCNT_LAST) begin
						if (dr_sel == BSTAP_DR_CFG_WR) begin
							wr_valid_d = 1'h1;
							wr_data_d = {tdi_s, w32_q[WW-1:1]};
						end
						if (dr_sel == BSTAP_DR_CFG_RD) begin
							// Empty buffer reads as zeros rather than stalling the tester
							w32_d = rd_valid ? rd_data : '0;
							rd_pop = rd_valid;
						end
					end
				end
				BSTAP_UPD_DR: begin
					if (dr_sel == BSTAP_DR_BSR) begin
						bsu_d = bsr_q;
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			bsr_q <= '0;
			bsu_q <= '0;
			w32_q <= '0;
			byp_q <= 1'h0;
			wcnt_q <= '0;
			wr_valid_q <= 1'h0;
			wr_data_q <= '0;
		end else begin
			bsr_q <= bsr_d;
			bsu_q <= bsu_d;
			w32_q <= w32_d;
			byp_q <= byp_d;
			wcnt_q <= wcnt_d;
			wr_valid_q <= wr_valid_d;
			wr_data_q <= wr_data_d;
		end
	end

	assign cfg_wr_valid_o = wr_valid_q;
	assign cfg_wr_data_o = wr_data_q;

	// Pins, test data out and user-chain strobes
	logic tdo_q, tdo_d, tdo_oe_q, tdo_oe_d;
	logic [N_IO-1:0] pad_out_q, pad_out_d, pad_oe_q, pad_oe_d, core_in_q, core_in_d;
	logic [N_IN-1:0] inonly_q, inonly_d;
	logic [8:0] usr_q, usr_d;
	logic ext, intest, dr_act;

	assign ext = (ir_q == `BSTAP_IR_EXTEST) || (ir_q == `BSTAP_IR_INTEST);
	assign intest = (ir_q == `BSTAP_IR_INTEST);
	assign dr_act = (state_q == BSTAP_CAP_DR) || (state_q == BSTAP_SH_DR);

	always_comb begin
		tdo_d = tdo_q;
		tdo_oe_d = tdo_oe_q;
		if (fall) begin
			tdo_oe_d = (state_q == BSTAP_SH_DR) || (state_q == BSTAP_SH_IR);
			if (state_q == BSTAP_SH_IR) begin
				tdo_d = ir_sh_q[0];
			end else if (state_q == BSTAP_SH_DR) begin
				case (dr_sel)
					BSTAP_DR_BSR: tdo_d = bsr_q[0];
					BSTAP_DR_IDCODE, BSTAP_DR_USERCODE: tdo_d = w32_q[0];
					BSTAP_DR_CFG_RD, BSTAP_DR_CFG_WR: tdo_d = w32_q[0];
					BSTAP_DR_USER_ONE: tdo_d = user_serial_out_one_i;
					BSTAP_DR_USER_TWO: tdo_d = user_serial_out_two_i;
					default: tdo_d = byp_q;
				endcase
			end
		end
		pad_out_d = ext ? bsu_out : core_out_i;
		pad_oe_d = (ir_q == `BSTAP_IR_HIGHZ) ? '0 : (ext ? bsu_oe : core_oe_i);
		core_in_d = intest ? bsu_in : pad_s;
		inonly_d = intest ? bsu_q[`BSTAP_CELLS_PER_IO * N_IO +: N_IN] : inp_s;
		// Select one, two, clock one, two, data in, reset, shift, update, start-up step
		usr_d[0] = (dr_sel == BSTAP_DR_USER_ONE);
		usr_d[1] = (dr_sel == BSTAP_DR_USER_TWO);
		usr_d[2] = usr_d[0] & dr_act & tck_s;
		usr_d[3] = usr_d[1] & dr_act & tck_s;
		usr_d[4] = tdi_s;
		usr_d[5] = (state_q == BSTAP_TLR);
		usr_d[6] = (state_q == BSTAP_SH_DR);
		usr_d[7] = (state_q == BSTAP_UPD_DR);
		usr_d[8] = rise & (ir_q == `BSTAP_IR_STARTUP) & (state_q == BSTAP_RTI)
			& startup_clock_source_i;
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			tdo_q <= 1'h0;
			tdo_oe_q <= 1'h0;
			pad_out_q <= '0;
			pad_oe_q <= '0;
			core_in_q <= '0;
			inonly_q <= '0;
			usr_q <= '0;
		end else begin
			tdo_q <= tdo_d;
			tdo_oe_q <= tdo_oe_d;
			pad_out_q <= pad_out_d;
			pad_oe_q <= pad_oe_d;
			core_in_q <= core_in_d;
			inonly_q <= inonly_d;
			usr_q <= usr_d;
		end
	end

	assign tdo_o = tdo_q;
	assign tdo_oe_o = tdo_oe_q;
	assign pad_out_o = pad_out_q;
	assign pad_oe_o = pad_oe_q;
	assign core_in_o = core_in_q;
	assign inonly_core_o = inonly_q;
	assign user_select_one_o = usr_q[0];
	assign user_select_two_o = usr_q[1];
	assign user_dr_clock_one_o = usr_q[2];
	assign user_dr_clock_two_o = usr_q[3];
	assign user_tdi_o = usr_q[4];
	assign user_reset_o = usr_q[5];
	assign user_shift_o = usr_q[6];
	assign user_update_o = usr_q[7];
	assign startup_step_o = usr_q[8];

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	ext_pads_a: assert property ((ir_q == `BSTAP_IR_EXTEST) |=> pad_oe_o == $past(bsu_oe))
		else $error("extest pad enable not from update cells");
	user_gate_a: assert property (!config_done_i && (ir_q == `BSTAP_IR_USER_TWO)
		|-> dr_sel == BSTAP_DR_BYPASS)
		else $error("user chain open before configuration");
	cfg_word_a: assert property (cfg_wr_valid_o
		|-> $past(dr_sel) == BSTAP_DR_CFG_WR && $past(wcnt_q) == `BSTAP_WCNT_LAST)
		else $error("configuration word emitted outside write");
	highz_pads_a: assert property ((ir_q == `BSTAP_IR_HIGHZ) |=> pad_oe_o == '0)
		else $error("output enabled during high impedance");
	startup_step_a: assert property (startup_step_o
		|-> $past(startup_clock_source_i) && $past(state_q) == BSTAP_RTI)
		else $error("start-up step without test clock source");
	reserved_byp_a: assert property ((ir_q == 5'h06 || ir_q == 5'h1E)
		|-> dr_sel == BSTAP_DR_BYPASS)
		else $error("reserved code not in bypass");
	id_lsb_a: assert property (rise && state_q == BSTAP_CAP_DR
		&& dr_sel == BSTAP_DR_IDCODE |=> w32_q == id_word)
		else $error("identification word not captured");
	ucode_blank_a: assert property (rise && state_q == BSTAP_CAP_DR
		&& dr_sel == BSTAP_DR_USERCODE && !config_done_i |=> w32_q == `BSTAP_USERCODE_BLANK)
		else $error("user code valid before configuration");
	bsr_capture_a: assert property (rise && state_q == BSTAP_CAP_DR
		&& dr_sel == BSTAP_DR_BSR |=> bsr_q[`BSTAP_CELL_OUT] == $past(core_out_i[0])
		&& bsr_q[`BSTAP_CELL_OE] == $past(core_oe_i[0]))
		else $error("boundary capture missed pin signals");
	tdo_drive_a: assert property (fall && state_q == BSTAP_SH_DR |=> tdo_oe_o ##1 tdo_oe_o [*2])
		else $error("test data out not driven in shift");
	sel_one_a: assert property (user_select_one_o
		|-> $past(dr_sel) == BSTAP_DR_USER_ONE && $past(config_done_i))
		else $error("user select one without its code");

	cfg_write_c: cover property (cfg_wr_valid_o);
	startup_c: cover property (startup_step_o);
	user_clock_c: cover property (user_dr_clock_two_o ##1 !user_dr_clock_two_o);
	readback_c: cover property (rd_pop && state_q == BSTAP_SH_DR);
endmodule

// file: bstap_ctl_model.sv
`timescale 1ns/10ps
module bstap_ctl_model (
	input wire logic clk_i,
	input wire logic tdo_i,
	output logic tck_o,
	output logic tms_o,
	output logic tdi_o
);
	// Test clock stands low between frames
	initial begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b0;
	end

	// Mode and data change while the test clock is low, at a falling edge of clk_i
	// Data out is taken just before the falling test clock edge that may change it
	task automatic tick(input logic m, input logic d, output logic o);
		tms_o = m;
		tdi_o = d;
		repeat (4) @(negedge clk_i);
		tck_o = 1'b1;
		repeat (4) @(negedge clk_i);
		o = tdo_i;
		tck_o = 1'b0;
	endtask

	task automatic reset_tap();
		logic o;
		repeat (5) tick(1'b1, 1'b0, o);
		tick(1'b0, 1'b0, o);
	endtask

	// From idle through capture, n shifts, update, back to idle
	task automatic scan(input logic ir, input int n, input logic [63:0] din,
		output logic [63:0] dout);
		logic o;
		dout = '0;
		tick(1'b1, 1'b0, o);
		if (ir)
			tick(1'b1, 1'b0, o);
		tick(1'b0, 1'b0, o);
		tick(1'b0, 1'b0, o);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], o);
			dout[i] = o;
		end
		tick(1'b1, 1'b0, o);
		tick(1'b0, 1'b0, o);
	endtask
endmodule

// file: bstap_top_tb.sv
`timescale 1ns/10ps
`include "bstap_consts.svh"
module bstap_top_tb;
	localparam logic [31:0] ID_EXP = {4'h3, 7'h11, 9'h068, 11'h2A5, 1'b1};
	logic clk = 1'b0;
	logic nrst, tck, tms, tdi, tdo, cfg_done, su_src, rd_valid, rd_ready;
	logic wr_valid, su_step, sel_one, sel_two, uso_one, uso_two;
	logic [31:0] ucode, rd_data, wr_data, wr_last;
	logic [7:0] pad_in, core_out, core_oe, pad_out, pad_oe;
	logic [1:0] inonly;
	logic tdo_oe, ureset, uupd, dck_one, dck_two, upd_prev, dck_one_prev, dck_two_prev;
	logic [7:0] core_in;
	logic [1:0] inonly_core;
	int upd_cnt = 0;
	int dck_one_cnt = 0;
	int dck_two_cnt = 0;
	logic [63:0] dout;
	int errors = 0;
	int checked = 0;
	int wr_cnt = 0;
	int su_cnt = 0;

	bstap_top #(.N_IO(8), .N_IN(2), .ID_VERSION(4'h3), .ID_FAMILY(7'h11), .ID_ROWS(9'h068),
		.ID_MAKER(11'h2A5)) bstap_top_i (.clk_i(clk), .nrst_i(nrst), .tck_i(tck),
		.tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .config_done_i(cfg_done),
		.startup_clock_source_i(su_src), .usercode_i(ucode), .cfg_rd_valid_i(rd_valid),
		.cfg_rd_data_i(rd_data), .cfg_rd_ready_o(rd_ready), .cfg_wr_valid_o(wr_valid),
		.cfg_wr_data_o(wr_data), .startup_step_o(su_step), .user_select_one_o(sel_one),
		.user_select_two_o(sel_two), .user_dr_clock_one_o(dck_one),
		.user_dr_clock_two_o(dck_two), .user_tdi_o(), .user_reset_o(ureset), .user_shift_o(),
		.user_update_o(uupd),
		.user_serial_out_one_i(uso_one), .user_serial_out_two_i(uso_two),
		.pad_in_i(pad_in), .core_out_i(core_out), .core_oe_i(core_oe), .pad_out_o(pad_out),
		.pad_oe_o(pad_oe), .core_in_o(core_in), .inonly_pad_i(inonly),
		.inonly_core_o(inonly_core));

	bstap_ctl_model bstap_ctl_model_i (.clk_i(clk), .tdo_i(tdo), .tck_o(tck), .tms_o(tms),
		.tdi_o(tdi));

	always #4 clk = ~clk;

	// Write and start-up pulses are one clock wide, so count them away from the launching edge
	always @(negedge clk) begin
		if (wr_valid === 1'b1) begin
			wr_cnt++;
			wr_last = wr_data;
		end
		if (su_step === 1'b1)
			su_cnt++;
		if (uupd === 1'b1 && upd_prev !== 1'b1)
			upd_cnt++;
		if (dck_one === 1'b1 && dck_one_prev !== 1'b1)
			dck_one_cnt++;
		if (dck_two === 1'b1 && dck_two_prev !== 1'b1)
			dck_two_cnt++;
		upd_prev = uupd;
		dck_one_prev = dck_one;
		dck_two_prev = dck_two;
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		if (errors == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic ir(input logic [4:0] c);
		bstap_ctl_model_i.scan(1'b1, 5, {59'h0, c}, dout);
		check(dout[4:0], `BSTAP_IR_CAPTURE);
		check(tdo_oe, 1'b0);
	endtask

	task automatic dr(input int n, input logic [63:0] din);
		int u;
		u = upd_cnt;
		bstap_ctl_model_i.scan(1'b0, n, din, dout);
		check(upd_cnt - u, 1);
	endtask

	task automatic push(input logic [31:0] d);
		int i;
		for (i = 0; i < 50 && rd_ready !== 1'b1; i++)
			@(negedge clk);
		if (i == 50) begin
			errors++;
			tally_and_finish();
		end
		rd_valid = 1'b1;
		rd_data = d;
		@(negedge clk);
		rd_valid = 1'b0;
		// Let an edge pass so a following push never re-raises valid in this step
		@(negedge clk);
	endtask

	task automatic t_bsr();
		logic [25:0] cap, pre;
		pre = 26'h2B4_E1D9;
		for (int k = 0; k < 8; k++)
			cap[3*k +: 3] = {core_oe[k], core_out[k], pad_in[k]};
		cap[25:24] = inonly;
		ir(`BSTAP_IR_SAMPLE);
		dr(26, {38'h0, pre});
		check(dout[25:0], cap);
		ir(`BSTAP_IR_EXTEST);
		for (int k = 0; k < 8; k++) begin
			check(pad_out[k], pre[3*k+1]);
			check(pad_oe[k], pre[3*k+2]);
		end
		ir(`BSTAP_IR_INTEST);
		for (int k = 0; k < 8; k++) begin
			check(core_in[k], pre[3*k]);
			check(pad_out[k], pre[3*k+1]);
		end
		check(inonly_core, pre[25:24]);
	endtask

	task automatic t_bypass();
		logic [4:0] codes [5] = '{`BSTAP_IR_BYPASS, 5'h06, 5'h1A, `BSTAP_IR_HIGHZ,
			`BSTAP_IR_STARTUP};
		for (int i = 0; i < 5; i++) begin
			ir(codes[i]);
			dr(8, 64'hA5);
			check(dout[7:0], 8'h4A);
			check(pad_oe, (codes[i] == `BSTAP_IR_HIGHZ) ? 8'h00 : core_oe);
		end
	endtask

	task automatic t_cfg();
		int n;
		n = wr_cnt;
		ir(`BSTAP_IR_CFG_WR);
		dr(32, 64'h8E3A_51C7);
		repeat (8) @(negedge clk);
		check(wr_cnt - n, 1);
		check(wr_last, 32'h8E3A_51C7);
		push(32'h0F1E_2D3C);
		push(32'hB4A5_9687);
		repeat (3) @(negedge clk);
		check(rd_ready, 1'b0);
		ir(`BSTAP_IR_CFG_RD);
		dr(64, 64'h0);
		check(dout, 64'hB4A5_9687_0F1E_2D3C);
		check(rd_ready, 1'b1);
	endtask

	task automatic t_startup();
		int n;
		logic o;
		su_src = 1'b1;
		ir(`BSTAP_IR_STARTUP);
		for (int s = 0; s < 2; s++) begin
			n = su_cnt;
			repeat (5) bstap_ctl_model_i.tick(1'b0, 1'b0, o);
			repeat (8) @(negedge clk);
			check(su_cnt - n, (s == 0) ? 5 : 0);
			su_src = 1'b0;
		end
	endtask

	task automatic t_user();
		int c1, c2;
		ir(`BSTAP_IR_USER_ONE);
		c1 = dck_one_cnt;
		dr(8, 64'hA5);
		check(dout[7:0], 8'h4A);
		check(sel_one, 1'b0);
		check(dck_one_cnt - c1, 0);
		ir(`BSTAP_IR_USERCODE);
		dr(32, 64'h0);
		check(dout[31:0], `BSTAP_USERCODE_BLANK);
		cfg_done = 1'b1;
		uso_one = 1'b1;
		ir(`BSTAP_IR_USER_ONE);
		check({sel_one, sel_two}, 2'b10);
		c1 = dck_one_cnt;
		c2 = dck_two_cnt;
		dr(8, 64'h0);
		check(dout[7:0], 8'hFF);
		check(dck_one_cnt - c1 >= 9, 1'b1);
		check(dck_two_cnt - c2, 0);
		uso_one = 1'b0;
		uso_two = 1'b1;
		ir(`BSTAP_IR_USER_TWO);
		check({sel_one, sel_two}, 2'b01);
		c1 = dck_one_cnt;
		c2 = dck_two_cnt;
		dr(8, 64'h0);
		check(dout[7:0], 8'hFF);
		check(dck_two_cnt - c2 >= 9, 1'b1);
		check(dck_one_cnt - c1, 0);
		ir(`BSTAP_IR_USERCODE);
		dr(32, 64'h0);
		check(dout[31:0], ucode);
	endtask

	initial begin
		#200000;
		errors++;
		tally_and_finish();
	end

	initial begin
		nrst = 1'b0;
		cfg_done = 1'b0;
		su_src = 1'b0;
		ucode = 32'h5A3C_96E1;
		rd_valid = 1'b0;
		rd_data = 32'h0;
		uso_one = 1'b0;
		uso_two = 1'b0;
		pad_in = 8'hC3;
		core_out = 8'h5A;
		core_oe = 8'h96;
		inonly = 2'b10;
		repeat (4) @(negedge clk);
		nrst = 1'b1;
		repeat (4) @(negedge clk);
		check(ureset, 1'b1);
		bstap_ctl_model_i.reset_tap();
		check(ureset, 1'b0);
		check(core_in, pad_in);
		check(inonly_core, inonly);
		dr(32, 64'h0);
		check(dout[31:0], ID_EXP);
		ir(`BSTAP_IR_IDCODE);
		dr(32, 64'h0);
		check(dout[31:0], ID_EXP);
		t_bsr();
		t_bypass();
		t_cfg();
		t_startup();
		t_user();
		tally_and_finish();
	end
endmodule
